// >>> src/mdr_map.svh
// Command codes, reply codes, field positions and reset values
`ifndef MDR_MAP_SVH
`define MDR_MAP_SVH

// Host command codes (bit seven always set)
`define MDR_CMD_SET_PROT 8'h81
`define MDR_CMD_GET_PROT 8'h82
`define MDR_CMD_SET_LIM 8'h83
`define MDR_CMD_GET_LIM 8'h84
`define MDR_CMD_GET_FLT0 8'h85
`define MDR_CMD_GET_FLT1 8'h86
`define MDR_CMD_SET_TIMING 8'h87
`define MDR_CMD_GET_TIMING 8'h88

// Reply code construction
`define MDR_CMD_MARK_BIT 7
`define MDR_ACK_BIT 6
`define MDR_UNSOL_FLT0 8'h85
`define MDR_UNSOL_FLT1 8'h86

// Protection configuration fields
`define MDR_PROT_RSVD_BIT 7
`define MDR_PROT_PULLUP_BIT 6
`define MDR_PROT_SLEEP_BIT 5
`define MDR_PROT_NEUSIM_BIT 4
`define MDR_PROT_EXT_UV_BIT 3
`define MDR_PROT_EXT_OC_BIT 2
`define MDR_PROT_OC_LIM_HI 1
`define MDR_PROT_OC_LIM_LO 0
`define MDR_PROT_RESET 8'h00
`define MDR_PROT_WMASK 8'h7f

// Current-limit reference code: threshold = base + code * step
`define MDR_LIM_RESET 8'h40
`define MDR_LIM_BASE_MV 991
`define MDR_LIM_STEP_UV 13770

// Fault word 1 layout
`define MDR_FLT1_EXT_UV_BIT 2
`define MDR_FLT1_EXT_OC_BIT 3
`define MDR_FLT1_CFG_LOST_BIT 4
`define MDR_FLT1_LDO_UV_BIT 5
`define MDR_FLT1_EVENT_MASK 8'h2c

`endif

// >>> src/mdr_pkg.sv
// Types shared by the host reply encoder
package mdr_pkg;

  // Command parser states
  typedef enum logic [1:0] {
    MDR_IDLE,
    MDR_DATA,
    MDR_WAIT
  } mdr_state_t;

endpackage : mdr_pkg

// >>> src/mdr_sync.sv
// Two-flop synchroniser, one chain per bit
`timescale 1ns/1ps
`default_nettype none

module mdr_sync #(
  parameter int WIDTH = 8
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  // Each bit gets its own chain; only the second stage is read
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      logic stage1;
      logic stage2;
      always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          stage1 <= 1'b0;
          stage2 <= 1'b0;
        end else begin
          stage1 <= async_in[i];
          stage2 <= stage1;
        end
      end
      // Each process owns its own two flops; the vector is only assembled here
      assign sync_out[i] = stage2;
    end
  endgenerate

endmodule : mdr_sync

`default_nettype wire

// >>> src/mdr_reply_sender.sv
// Sends a one- or two-byte reply message over a valid/ready byte port
`timescale 1ns/1ps
`default_nettype none

module mdr_reply_sender (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic launch,
  input wire logic [7:0] code,
  input wire logic [7:0] data,
  input wire logic has_data,
  output logic busy,
  output logic reply_valid,
  output logic [7:0] reply_byte,
  input wire logic reply_ready
);

  logic [7:0] held_data;
  logic second_due;

  // Byte presenter: code first, then the data byte if any
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      busy <= 1'b0;
      reply_valid <= 1'b0;
      reply_byte <= 8'h00;
      held_data <= 8'h00;
      second_due <= 1'b0;
    end else if (launch && !busy) begin
      busy <= 1'b1;
      reply_valid <= 1'b1;
      reply_byte <= code;
      held_data <= data;
      second_due <= has_data;
    end else if (reply_valid && reply_ready) begin
      if (second_due) begin
        reply_byte <= held_data;
        second_due <= 1'b0;
      end else begin
        reply_valid <= 1'b0;
        busy <= 1'b0;
      end
    end
  end

endmodule : mdr_reply_sender

`default_nettype wire

// >>> src/mdr_reply_encoder.sv
// Host message link command interpreter and reply/report encoder
`include "mdr_map.svh"
`timescale 1ns/1ps
`default_nettype none

module mdr_reply_encoder (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_byte,
  output logic cmd_ready,
  output logic reply_valid,
  output logic [7:0] reply_byte,
  input wire logic reply_ready,
  input wire logic chip_enable,
  input wire logic [7:0] supply_thermal_faults,
  input wire logic ext_undervoltage_lockout,
  input wire logic ext_overcurrent,
  input wire logic ldo_undervoltage_lockout,
  output logic pullup_disconnect,
  output logic sleep_active,
  output logic standby_active,
  output logic neutral_sim_enable,
  output logic ext_uv_lockout_enable,
  output logic ext_oc_detect_enable,
  output logic [1:0] ext_oc_threshold,
  output logic [7:0] current_limit_code
);

  logic rst_meta_n;
  logic rst_sync_n;
  logic [7:0] flt0_sync;
  logic [3:0] pin_sync;
  logic ce_s;
  logic [7:0] flt0;
  logic [7:0] flt1_live;
  logic [7:0] flt1;
  logic [7:0] flt0_prev;
  logic [7:0] flt1_prev;
  logic unsol0_pend;
  logic unsol1_pend;
  logic cfg_lost;
  logic [7:0] driver_protection_config;
  logic [7:0] current_limit_reference;
  mdr_pkg::mdr_state_t state;
  mdr_pkg::mdr_state_t next_state;
  logic [7:0] pend_cmd;
  logic accept;
  logic is_cmd;
  logic launch;
  logic [7:0] launch_code;
  logic [7:0] launch_data;
  logic launch_has_data;
  logic sender_busy;
  logic send_flt1;
  logic send_unsol0;
  logic send_unsol1;
  logic prot_ok;
  logic [7:0] prot_new;

  // Reset release through two flops
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_n <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_sync_n <= rst_meta_n;
    end
  end

  // Analog flags and the enable pin cross into the clock domain
  mdr_sync #(.WIDTH(8)) u_sync_flt0 (
    .clock(clock),
    .rst_n(rst_sync_n),
    .async_in(supply_thermal_faults),
    .sync_out(flt0_sync)
  );

  mdr_sync #(.WIDTH(4)) u_sync_pins (
    .clock(clock),
    .rst_n(rst_sync_n),
    .async_in({chip_enable, ldo_undervoltage_lockout, ext_overcurrent,
               ext_undervoltage_lockout}),
    .sync_out(pin_sync)
  );

  assign ce_s = pin_sync[3];
  assign flt0 = flt0_sync;
  // Fault word 1 assembly, reserved bits zero
  always_comb begin
    flt1_live = 8'h00;
    flt1_live[`MDR_FLT1_EXT_UV_BIT] = pin_sync[0];
    flt1_live[`MDR_FLT1_EXT_OC_BIT] = pin_sync[1];
    flt1_live[`MDR_FLT1_LDO_UV_BIT] = pin_sync[2];
    flt1 = flt1_live;
    flt1[`MDR_FLT1_CFG_LOST_BIT] = cfg_lost;
  end

  // Command decode helpers
  assign accept = cmd_valid && cmd_ready;
  assign is_cmd = cmd_byte[`MDR_CMD_MARK_BIT];
  assign send_flt1 = accept && (cmd_byte == `MDR_CMD_GET_FLT1);
  assign send_unsol0 = launch && (launch_code == `MDR_UNSOL_FLT0);
  assign send_unsol1 = launch && (launch_code == `MDR_UNSOL_FLT1);

  // Protection write: reserved bit must be zero, pull-up bit may only
  // change in standby so a live pull-up is never switched underneath
  always_comb begin
    prot_new = cmd_byte & `MDR_PROT_WMASK;
    prot_ok = !cmd_byte[`MDR_PROT_RSVD_BIT];
    if ((prot_new[`MDR_PROT_PULLUP_BIT] !=
         driver_protection_config[`MDR_PROT_PULLUP_BIT]) &&
        !standby_active) begin
      prot_ok = 1'b0;
    end
  end

  // Parser and reply selection
  always_comb begin
    next_state = state;
    launch = 1'b0;
    launch_code = 8'h00;
    launch_data = 8'h00;
    launch_has_data = 1'b0;
    case (state)
      mdr_pkg::MDR_IDLE: begin
        if (accept && is_cmd) begin
          launch_code = {1'b0, 1'b1, cmd_byte[5:0]};
          launch_has_data = 1'b1;
          case (cmd_byte)
            `MDR_CMD_SET_PROT,
            `MDR_CMD_SET_LIM,
            `MDR_CMD_SET_TIMING: begin
              next_state = mdr_pkg::MDR_DATA;
            end
            `MDR_CMD_GET_PROT: begin
              launch = 1'b1;
              launch_data = driver_protection_config;
            end
            `MDR_CMD_GET_LIM: begin
              launch = 1'b1;
              launch_data = current_limit_reference;
            end
            `MDR_CMD_GET_FLT0: begin
              launch = 1'b1;
              launch_data = flt0;
            end
            `MDR_CMD_GET_FLT1: begin
              launch = 1'b1;
              launch_data = flt1;
            end
            `MDR_CMD_GET_TIMING: begin
              launch = 1'b1;
              launch_code = {2'b00, cmd_byte[5:0]};
              launch_has_data = 1'b0;
            end
            default: begin
              launch_has_data = 1'b0;
            end
          endcase
          if (launch) begin
            next_state = mdr_pkg::MDR_WAIT;
          end
        end else if (!accept && unsol0_pend) begin
          launch = 1'b1;
          launch_code = `MDR_UNSOL_FLT0;
          launch_data = flt0;
          launch_has_data = 1'b1;
          next_state = mdr_pkg::MDR_WAIT;
        end else if (!accept && unsol1_pend) begin
          launch = 1'b1;
          launch_code = `MDR_UNSOL_FLT1;
          launch_data = flt1;
          launch_has_data = 1'b1;
          next_state = mdr_pkg::MDR_WAIT;
        end
      end
      mdr_pkg::MDR_DATA: begin
        if (accept) begin
          launch = 1'b1;
          launch_has_data = 1'b1;
          next_state = mdr_pkg::MDR_WAIT;
          case (pend_cmd)
            `MDR_CMD_SET_PROT: begin
              launch_code = {1'b0, prot_ok, pend_cmd[5:0]};
              launch_data = prot_ok ? prot_new : driver_protection_config;
            end
            `MDR_CMD_SET_LIM: begin
              launch_code = {1'b0, 1'b1, pend_cmd[5:0]};
              launch_data = cmd_byte;
            end
            default: begin
              launch_code = {2'b00, pend_cmd[5:0]};
              launch_has_data = 1'b0;
            end
          endcase
        end
      end
      mdr_pkg::MDR_WAIT: begin
        if (!sender_busy) begin
          next_state = mdr_pkg::MDR_IDLE;
        end
      end
      default: begin
        next_state = mdr_pkg::MDR_IDLE;
      end
    endcase
  end

  // Parser state, remembered command and input handshake
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      state <= mdr_pkg::MDR_IDLE;
      pend_cmd <= 8'h00;
      cmd_ready <= 1'b0;
    end else begin
      state <= next_state;
      if (accept && state == mdr_pkg::MDR_IDLE) begin
        pend_cmd <= cmd_byte;
      end
      cmd_ready <= (next_state != mdr_pkg::MDR_WAIT);
    end
  end

  // Configuration registers, updated on accepted writes
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      driver_protection_config <= `MDR_PROT_RESET;
      current_limit_reference <= `MDR_LIM_RESET;
    end else if (accept && state == mdr_pkg::MDR_DATA) begin
      if (pend_cmd == `MDR_CMD_SET_PROT && prot_ok) begin
        driver_protection_config <= prot_new;
      end
      if (pend_cmd == `MDR_CMD_SET_LIM) begin
        current_limit_reference <= cmd_byte;
      end
    end
  end

  // Configuration-lost flag: set by reset, cleared once fault word 1
  // has been reported
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      cfg_lost <= 1'b1;
    end else if (send_unsol1 || (launch && send_flt1 &&
                 state == mdr_pkg::MDR_IDLE)) begin
      cfg_lost <= 1'b0;
    end
  end

  // Rising fault flags arm an unsolicited report; a new rise wins over
  // the clear made by the report in flight
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      flt0_prev <= 8'h00;
      flt1_prev <= 8'h00;
      unsol0_pend <= 1'b0;
      unsol1_pend <= 1'b0;
    end else begin
      flt0_prev <= flt0;
      flt1_prev <= flt1_live;
      if (|(flt0 & ~flt0_prev)) begin
        unsol0_pend <= 1'b1;
      end else if (send_unsol0) begin
        unsol0_pend <= 1'b0;
      end
      if (|(flt1_live & ~flt1_prev & `MDR_FLT1_EVENT_MASK)) begin
        unsol1_pend <= 1'b1;
      end else if (send_unsol1) begin
        unsol1_pend <= 1'b0;
      end
    end
  end

  // Control outputs derived from the configuration and enable pin
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      pullup_disconnect <= 1'b0;
      sleep_active <= 1'b0;
      standby_active <= 1'b0;
      neutral_sim_enable <= 1'b0;
      ext_uv_lockout_enable <= 1'b1;
      ext_oc_detect_enable <= 1'b1;
      ext_oc_threshold <= 2'b00;
      current_limit_code <= `MDR_LIM_RESET;
    end else begin
      sleep_active <= !ce_s &&
        driver_protection_config[`MDR_PROT_SLEEP_BIT];
      standby_active <= !ce_s &&
        !driver_protection_config[`MDR_PROT_SLEEP_BIT];
      pullup_disconnect <= !ce_s &&
        (!driver_protection_config[`MDR_PROT_PULLUP_BIT] ||
         driver_protection_config[`MDR_PROT_SLEEP_BIT]);
      neutral_sim_enable <=
        driver_protection_config[`MDR_PROT_NEUSIM_BIT];
      ext_uv_lockout_enable <=
        !driver_protection_config[`MDR_PROT_EXT_UV_BIT];
      ext_oc_detect_enable <=
        !driver_protection_config[`MDR_PROT_EXT_OC_BIT];
      ext_oc_threshold <= driver_protection_config[
        `MDR_PROT_OC_LIM_HI:`MDR_PROT_OC_LIM_LO];
      current_limit_code <= current_limit_reference;
    end
  end

  // Reply byte sequencer
  mdr_reply_sender u_sender (
    .clock(clock),
    .rst_n(rst_sync_n),
    .launch(launch),
    .code(launch_code),
    .data(launch_data),
    .has_data(launch_has_data),
    .busy(sender_busy),
    .reply_valid(reply_valid),
    .reply_byte(reply_byte),
    .reply_ready(reply_ready)
  );

endmodule : mdr_reply_encoder

`default_nettype wire

// >>> verification/mdr_reply_encoder_assertions.sv
// Port checks for the host reply encoder
`timescale 1ns/1ps
`default_nettype none

module mdr_reply_encoder_checker (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_byte,
  input wire logic cmd_ready,
  input wire logic reply_valid,
  input wire logic [7:0] reply_byte,
  input wire logic reply_ready,
  input wire logic chip_enable,
  input wire logic [7:0] supply_thermal_faults,
  input wire logic pullup_disconnect,
  input wire logic sleep_active,
  input wire logic standby_active,
  input wire logic neutral_sim_enable,
  input wire logic ext_uv_lockout_enable,
  input wire logic ext_oc_detect_enable,
  input wire logic [1:0] ext_oc_threshold,
  input wire logic [7:0] current_limit_code
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  logic take;
  logic want_data;
  logic second;
  logic [7:0] last_cmd;
  assign take = cmd_valid && cmd_ready;
  // Track data bytes of set commands and the second byte of replies
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      want_data <= 1'b0;
      second <= 1'b0;
      last_cmd <= 8'h00;
    end else begin
      last_cmd <= cmd_byte;
      if (take) begin
        want_data <= !want_data && cmd_byte inside {8'h81, 8'h83, 8'h87};
      end
      if (reply_valid && reply_ready) begin
        second <= second ? 1'b0 : !(reply_byte inside {8'h07, 8'h08});
      end
    end
  end
  property p_get_ack;
    take && !want_data && cmd_byte inside {8'h82, 8'h84, 8'h85, 8'h86}
      |=> reply_valid && reply_byte == {2'b01, last_cmd[5:0]};
  endproperty
  a_get_ack: assert property (p_get_ack) else $error("poll reply code");
  property p_timing_nak;
    take && !want_data && cmd_byte == 8'h88 |=> reply_valid ##0
      reply_byte == 8'h08;
  endproperty
  a_timing_nak: assert property (p_timing_nak) else $error("nak code");
  property p_reply_hold;
    reply_valid && !reply_ready |=> reply_valid && $stable(reply_byte);
  endproperty
  a_reply_hold: assert property (p_reply_hold) else $error("reply moved");
  property p_busy;
    reply_valid |-> !cmd_ready;
  endproperty
  a_busy: assert property (p_busy) else $error("ready while replying");
  property p_first_code;
    reply_valid && !second |-> reply_byte inside
      {[8'h01:8'h08], [8'h41:8'h46], 8'h85, 8'h86};
  endproperty
  a_first_code: assert property (p_first_code) else $error("bad code");
  property p_cfg_bit7;
    reply_valid && reply_ready && !second && reply_byte inside
      {8'h01, 8'h41, 8'h42} |=> reply_valid && !reply_byte[7];
  endproperty
  a_cfg_bit7: assert property (p_cfg_bit7) else $error("cfg bit 7");
  property p_unsol0;
    (supply_thermal_faults & ~$past(supply_thermal_faults)) != 8'h00
      |-> ##[1:40] reply_valid && !second && reply_byte == 8'h85;
  endproperty
  a_unsol0: assert property (p_unsol0) else $error("no fault report");
  property p_ce_high;
    chip_enable [*8] |-> !sleep_active && !standby_active &&
      !pullup_disconnect;
  endproperty
  a_ce_high: assert property (p_ce_high) else $error("low power on");
  property p_ce_low;
    !chip_enable [*8] |-> sleep_active != standby_active;
  endproperty
  a_ce_low: assert property (p_ce_low) else $error("no low power");
  property p_sleep_pullup;
    sleep_active |-> pullup_disconnect;
  endproperty
  a_sleep_pullup: assert property (p_sleep_pullup) else $error("pullup");
  property p_defaults;
    $rose(rst_n) |-> !neutral_sim_enable && ext_uv_lockout_enable &&
      ext_oc_detect_enable && ext_oc_threshold == 2'b00 &&
      current_limit_code == 8'h40;
  endproperty
  a_defaults: assert property (p_defaults) else $error("defaults");
  c_set_cfg: cover property (take && cmd_byte == 8'h81);
  c_unsol: cover property (reply_valid && !second && reply_byte == 8'h85);
  c_sleep: cover property (sleep_active);
endmodule : mdr_reply_encoder_checker

bind mdr_reply_encoder mdr_reply_encoder_checker chk_u (
  .clock(clock), .rst_n(rst_n), .cmd_valid(cmd_valid),
  .cmd_byte(cmd_byte), .cmd_ready(cmd_ready), .reply_valid(reply_valid),
  .reply_byte(reply_byte), .reply_ready(reply_ready),
  .chip_enable(chip_enable), .supply_thermal_faults(supply_thermal_faults),
  .pullup_disconnect(pullup_disconnect), .sleep_active(sleep_active),
  .standby_active(standby_active), .neutral_sim_enable(neutral_sim_enable),
  .ext_uv_lockout_enable(ext_uv_lockout_enable),
  .ext_oc_detect_enable(ext_oc_detect_enable),
  .ext_oc_threshold(ext_oc_threshold),
  .current_limit_code(current_limit_code));

`default_nettype wire

// >>> verification/mdr_host_model.sv
// Host side of the reply link: takes bytes promptly or while stalling
`timescale 1ns/1ps
`default_nettype none

module mdr_host_model (
  input wire logic clock,
  input wire logic reply_valid,
  input wire logic [7:0] reply_byte,
  output logic reply_ready = 1'b0
);
  bit slow = 1'b0;
  logic [1:0] phase = 2'b00;
  logic [7:0] got[$];
  // When slow, ready is high one cycle in four
  always @(negedge clock) begin
    phase <= phase + 2'b01;
    reply_ready <= !slow || phase == 2'b11;
  end
  // Keep each byte at the edge where it is taken
  always @(posedge clock) begin
    if (reply_valid && reply_ready) begin
      got.push_back(reply_byte);
    end
  end
endmodule : mdr_host_model

`default_nettype wire

// >>> verification/testbench.sv
// Self-checking bench for the host reply encoder
`timescale 1ns/1ps
`default_nettype none

module testbench;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic cmd_valid = 1'b0;
  logic [7:0] cmd_byte = 8'h00;
  logic chip_enable = 1'b1;
  logic [7:0] supply_thermal_faults = 8'h00;
  logic ext_uv = 1'b0;
  logic ext_oc = 1'b0;
  logic ldo_uv = 1'b0;
  logic cmd_ready, reply_valid, reply_ready, pullup_disconnect;
  logic sleep_active, standby_active, neutral_sim_enable;
  logic ext_uv_lockout_enable, ext_oc_detect_enable;
  logic [1:0] ext_oc_threshold;
  logic [7:0] reply_byte, current_limit_code, d;
  int miscompares = 0;
  int n_compared = 0;
  int cycles = 0;

  always #50 clock = !clock;

  mdr_reply_encoder dut_u (.clock(clock), .rst_n(rst_n),
    .cmd_valid(cmd_valid), .cmd_byte(cmd_byte), .cmd_ready(cmd_ready),
    .reply_valid(reply_valid), .reply_byte(reply_byte),
    .reply_ready(reply_ready), .chip_enable(chip_enable),
    .supply_thermal_faults(supply_thermal_faults),
    .ext_undervoltage_lockout(ext_uv), .ext_overcurrent(ext_oc),
    .ldo_undervoltage_lockout(ldo_uv),
    .pullup_disconnect(pullup_disconnect), .sleep_active(sleep_active),
    .standby_active(standby_active), .neutral_sim_enable(neutral_sim_enable),
    .ext_uv_lockout_enable(ext_uv_lockout_enable),
    .ext_oc_detect_enable(ext_oc_detect_enable),
    .ext_oc_threshold(ext_oc_threshold),
    .current_limit_code(current_limit_code));
  mdr_host_model host_u (.clock(clock), .reply_valid(reply_valid),
    .reply_byte(reply_byte), .reply_ready(reply_ready));

  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : conclude

  // Cut a hang short
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      conclude();
    end
  end

  task automatic check(string what, logic [7:0] exp, logic [7:0] seen);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Offer one byte and hold it until the taking edge
  task automatic send(logic [7:0] b);
    int n;
    n = 0;
    @(negedge clock);
    cmd_valid = 1'b1;
    cmd_byte = b;
    @(posedge clock);
    while (cmd_ready !== 1'b1 && n < 200) begin
      n++;
      @(posedge clock);
    end
    @(negedge clock);
    cmd_valid = 1'b0;
  endtask : send

  // Wait for a whole reply, then compare count and bytes
  task automatic expect_reply(logic [7:0] b0, logic [7:0] b1, int n);
    int w;
    w = 0;
    while (host_u.got.size() < n && w < 100) begin
      w++;
      @(posedge clock);
    end
    repeat (6) @(negedge clock);
    check("reply count", 8'(n), 8'(host_u.got.size()));
    if (host_u.got.size() > 0 && n > 0) check("code", b0, host_u.got[0]);
    if (host_u.got.size() > 1 && n > 1) check("data", b1, host_u.got[1]);
    host_u.got.delete();
  endtask : expect_reply

  task automatic xfer(logic [7:0] c, logic [7:0] dt, bit two,
                      logic [7:0] b0, logic [7:0] b1, int n);
    send(c);
    if (two) send(dt);
    expect_reply(b0, b1, n);
  endtask : xfer

  initial begin
    repeat (12) @(negedge clock);
    rst_n = 1'b1;
    repeat (6) @(negedge clock);
    check("neutral sim", 8'h00, {7'h00, neutral_sim_enable});
    check("uv enable", 8'h01, {7'h00, ext_uv_lockout_enable});
    check("oc enable", 8'h01, {7'h00, ext_oc_detect_enable});
    check("limit code", 8'h40, current_limit_code);
    xfer(8'h82, 8'h00, 0, 8'h42, 8'h00, 2);
    xfer(8'h86, 8'h00, 0, 8'h46, 8'h10, 2);
    xfer(8'h86, 8'h00, 0, 8'h46, 8'h00, 2);
    xfer(8'h84, 8'h00, 0, 8'h44, 8'h40, 2);
    $display("test defaults done");
    for (int i = 0; i < 4; i++) begin
      d = (i == 3) ? 8'h1f : 8'(i * 5);
      xfer(8'h81, d, 1, 8'h41, d, 2);
      check("threshold", 8'(i), {6'h00, ext_oc_threshold});
      check("oc enable", {7'h00, !d[2]}, {7'h00, ext_oc_detect_enable});
      check("uv enable", {7'h00, !d[3]}, {7'h00, ext_uv_lockout_enable});
      check("neutral", {7'h00, d[4]}, {7'h00, neutral_sim_enable});
    end
    xfer(8'h81, 8'h5f, 1, 8'h01, 8'h1f, 2);
    xfer(8'h81, 8'h9f, 1, 8'h01, 8'h1f, 2);
    chip_enable = 1'b0;
    repeat (6) @(negedge clock);
    check("standby", 8'h01, {7'h00, standby_active});
    check("disconnect", 8'h01, {7'h00, pullup_disconnect});
    xfer(8'h81, 8'h5f, 1, 8'h41, 8'h5f, 2);
    check("disconnect", 8'h00, {7'h00, pullup_disconnect});
    xfer(8'h81, 8'h7f, 1, 8'h41, 8'h7f, 2);
    check("sleep", 8'h01, {7'h00, sleep_active});
    check("disconnect", 8'h01, {7'h00, pullup_disconnect});
    chip_enable = 1'b1;
    $display("test config done");
    xfer(8'h83, 8'hff, 1, 8'h43, 8'hff, 2);
    check("limit code", 8'hff, current_limit_code);
    host_u.slow = 1'b1;
    xfer(8'h83, 8'h00, 1, 8'h43, 8'h00, 2);
    xfer(8'h84, 8'h00, 0, 8'h44, 8'h00, 2);
    host_u.slow = 1'b0;
    xfer(8'h87, 8'h3c, 1, 8'h07, 8'h00, 1);
    xfer(8'h88, 8'h00, 0, 8'h08, 8'h00, 1);
    xfer(8'h89, 8'h00, 0, 8'h00, 8'h00, 0);
    xfer(8'h12, 8'h00, 0, 8'h00, 8'h00, 0);
    $display("test limit and codes done");
    for (int i = 0; i < 8; i++) begin
      supply_thermal_faults = 8'h01 << i;
      expect_reply(8'h85, 8'h01 << i, 2);
    end
    ext_uv = 1'b1;
    expect_reply(8'h86, 8'h04, 2);
    ext_oc = 1'b1;
    expect_reply(8'h86, 8'h0c, 2);
    ldo_uv = 1'b1;
    expect_reply(8'h86, 8'h2c, 2);
    xfer(8'h85, 8'h00, 0, 8'h45, 8'h80, 2);
    xfer(8'h86, 8'h00, 0, 8'h46, 8'h2c, 2);
    $display("test fault reports done");
    conclude();
  end
endmodule : testbench

`default_nettype wire
